// ===== logic/troc_pkg.sv
// package for the test result output control block
package troc_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_MS = 10;
   localparam logic [19:0] TICK_CYC = 20'(CLK_HZ / 1000 * TICK_MS);
   localparam logic [9:0] MAX_STEPS = 10'h3e8;
   localparam int unsigned IDLE_MIN = 2;
   localparam logic [13:0] IDLE_TICKS = 14'(IDLE_MIN * 60 * 1000 / TICK_MS);
   localparam logic [2:0] STABLE_UNITS = 3'h5;
   localparam logic [3:0] FLASH_TICKS = 4'h0;
   localparam logic [3:0] FLASH_HALF = 4'h9;
   // register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PASS_TIME = 8'h04;
   localparam logic [7:0] A_FAIL_TIME = 8'h08;
   localparam logic [7:0] A_TONE_PASS = 8'h0c;
   localparam logic [7:0] A_TONE_FAIL = 8'h10;
   localparam logic [7:0] A_EVENT = 8'h14;
   localparam logic [7:0] A_STATUS = 8'h18;
   localparam logic [7:0] A_LOAD = 8'h1c;
   // control fields
   localparam int unsigned C_PASS_MODE = 0;
   localparam int unsigned C_FAIL_MODE = 2;
   localparam int unsigned C_BEEP_PASS = 4;
   localparam int unsigned C_BEEP_FAIL = 5;
   localparam int unsigned C_ROUTE_SUP = 6;
   localparam int unsigned C_HOLD_POS = 7;
   localparam int unsigned C_MTX_HOLD = 8;
   localparam int unsigned C_LAMP_FLASH = 9;
   localparam int unsigned C_ADAPTIVE = 10;
   localparam int unsigned C_ANALOG_DIS = 11;
   localparam int unsigned C_CONTACT_START = 12;
   localparam logic [31:0] CTRL_RST = 32'h0000_0040;
   localparam logic [31:0] CTRL_MASK = 32'h0000_1fff;
   localparam logic [9:0] TONE_PASS_RST = 10'h0c8;
   localparam logic [9:0] TONE_FAIL_RST = 10'h1f4;
   // event write bits
   localparam int unsigned E_PASS = 0;
   localparam int unsigned E_FAIL = 1;
   localparam int unsigned E_PLAN_END = 2;
   localparam int unsigned E_STEP_START = 3;
   localparam int unsigned E_STEP_DONE = 4;
   localparam int unsigned E_MTX_ARM = 5;
   localparam int unsigned E_UNIT = 6;
   localparam int unsigned E_GPO0 = 7;
   localparam int unsigned E_GPO1 = 8;
   typedef enum logic [1:0] {M_OFF, M_LATCH, M_TIME, M_SAFETY} troc_mode_e;
endpackage

// ===== logic/troc_top.sv
// test result output control with apb registers
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
// How it works
// R1: timed mode holds the chosen result output until the programmed count of 10 ms ticks, so up to one 10 ms step short.
// R2: duration counts 10 ms steps, limited to 10 seconds.
// R3: controller spaces test starts more than 200 ms apart.
// R4: controller holds start input changes longer than 18 ms.
// R5: controller picks duration as poll cycle plus 18 ms, rounded up.
// R6: safety mode holds the result while the safety input stays active.
// R7: safety mode starts only a whole test plan.
// R8: beep enables sound the buzzer on that result for its tone duration.
// R9: pass beep enable also sounds the buzzer once after power-on; the enable resets clear, so no power-on beep sounds.
// R10: suppress clear forwards safety-closed and contacting-closed status out.
// R11: suppress set drives those outputs per step as general controls.
// R12: plan end returns matrix to default unless hold-position is set.
// R13: armed matrix step not started switches the matrix off after 2 minutes.
// R14: matrix-hold with contact-monitoring start suppresses the switch-off.
// R15: lamp-flash flag flashes the red lamp during an active test.
// R16: each ac hv test normally does an intermediate load measurement.
// R17: adaptive mode skips it after 5 units with unchanged load.
// R18: voltage or load change restores it and restarts the count.
// R19: analog-output disable stops analog value presentation.
// R20: in-operation and ready toggle once per test step.
// R21: duration counter steps on a 10 ms tick and clears on reset.
module troc_top (
   // clock, reset, enable
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic CLK_EN,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // control interface inputs
   input wire logic SAFETY_IN,
   input wire logic SAFETY_CLOSED,
   input wire logic CONTACT_CLOSED,
   input wire logic AC_HV_TEST,
   // control interface outputs
   output logic PASS_OUT,
   output logic FAIL_OUT,
   output logic SAFETY_CLOSED_OUT,
   output logic CONTACT_CLOSED_OUT,
   output logic IN_OPERATION,
   output logic READY_OUT,
   output logic PLAN_START,
   output logic BUZZER,
   output logic WARN_LAMP,
   output logic MATRIX_ON,
   output logic MATRIX_DEFAULT,
   output logic LOAD_MEASURE,
   output logic ANALOG_EN
);
   logic [31:0] ctrl_q;
   logic [9:0] pass_time_q, fail_time_q, tone_pass_q, tone_fail_q;
   logic [19:0] tick_cnt_q;
   logic tick;
   logic [9:0] res_cnt_q, tone_cnt_q;
   logic [13:0] idle_cnt_q;
   logic [2:0] stable_q;
   logic [15:0] volt_q, load_q;
   logic [3:0] flash_q;
   logic test_active_q, por_beep_q, gpo0_q, gpo1_q, safety_prev_q, mtx_armed_q;
   logic wr, rd, mapped;
   logic [31:0] ev;
   localparam logic [9:0] MAX_STEPS = troc_pkg::MAX_STEPS;
   localparam logic [3:0] FLASH_HALF = troc_pkg::FLASH_HALF;
   localparam logic [2:0] STABLE_UNITS = troc_pkg::STABLE_UNITS;
   localparam int unsigned C_BEEP_PASS = troc_pkg::C_BEEP_PASS;
   localparam int unsigned C_BEEP_FAIL = troc_pkg::C_BEEP_FAIL;
   localparam int unsigned C_ROUTE_SUP = troc_pkg::C_ROUTE_SUP;
   localparam int unsigned C_HOLD_POS = troc_pkg::C_HOLD_POS;
   localparam int unsigned C_MTX_HOLD = troc_pkg::C_MTX_HOLD;
   localparam int unsigned C_LAMP_FLASH = troc_pkg::C_LAMP_FLASH;
   localparam int unsigned C_ADAPTIVE = troc_pkg::C_ADAPTIVE;
   localparam int unsigned C_ANALOG_DIS = troc_pkg::C_ANALOG_DIS;
   localparam int unsigned C_CONTACT_START = troc_pkg::C_CONTACT_START;

   function automatic logic [9:0] clamp_steps(input logic [31:0] v);
      clamp_steps = (v > 32'(MAX_STEPS)) ? MAX_STEPS : v[9:0];
   endfunction

   function automatic troc_pkg::troc_mode_e mode_of(input logic [1:0] f);
      mode_of = troc_pkg::troc_mode_e'(f);
   endfunction

   assign wr = PSEL && PENABLE && PWRITE && CLK_EN;
   assign rd = PSEL && !PENABLE && !PWRITE;
   assign ev = (wr && PADDR == troc_pkg::A_EVENT) ? PWDATA : 32'h0000_0000;
   assign tick = (tick_cnt_q == troc_pkg::TICK_CYC - 20'h00001);
   always_comb begin
      case (PADDR)
         troc_pkg::A_CTRL, troc_pkg::A_PASS_TIME, troc_pkg::A_FAIL_TIME, troc_pkg::A_TONE_PASS,
         troc_pkg::A_TONE_FAIL, troc_pkg::A_EVENT, troc_pkg::A_STATUS, troc_pkg::A_LOAD: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // apb: zero wait states, read data set up during the setup phase
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         PRDATA <= 32'h0000_0000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else if (CLK_EN) begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !mapped;
         if (rd) begin
            case (PADDR)
               troc_pkg::A_CTRL: PRDATA <= ctrl_q;
               troc_pkg::A_PASS_TIME: PRDATA <= {22'h000000, pass_time_q};
               troc_pkg::A_FAIL_TIME: PRDATA <= {22'h000000, fail_time_q};
               troc_pkg::A_TONE_PASS: PRDATA <= {22'h000000, tone_pass_q};
               troc_pkg::A_TONE_FAIL: PRDATA <= {22'h000000, tone_fail_q};
               troc_pkg::A_STATUS: PRDATA <= {16'h0000, 2'h0, res_cnt_q, stable_q, test_active_q};
               troc_pkg::A_LOAD: PRDATA <= {volt_q, load_q};
               default: PRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   // config registers, pulse lengths limited to 10 s
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         ctrl_q <= troc_pkg::CTRL_RST;
         pass_time_q <= 10'h000;
         fail_time_q <= 10'h000;
         tone_pass_q <= troc_pkg::TONE_PASS_RST;
         tone_fail_q <= troc_pkg::TONE_FAIL_RST;
      end else if (wr) begin
         case (PADDR)
            troc_pkg::A_CTRL: ctrl_q <= PWDATA & troc_pkg::CTRL_MASK;
            troc_pkg::A_PASS_TIME: pass_time_q <= clamp_steps(PWDATA); // R2
            troc_pkg::A_FAIL_TIME: fail_time_q <= clamp_steps(PWDATA); // R2
            troc_pkg::A_TONE_PASS: tone_pass_q <= clamp_steps(PWDATA);
            troc_pkg::A_TONE_FAIL: tone_fail_q <= clamp_steps(PWDATA);
            default: ;
         endcase
      end
   end

   // 10 ms timebase
   always_ff @(posedge CORE_CLK) begin
      if (!NRST)
         tick_cnt_q <= 20'h00000; // R21
      else if (CLK_EN)
         tick_cnt_q <= tick ? 20'h00000 : tick_cnt_q + 20'h00001; // R21
   end

   // result outputs per mode
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         PASS_OUT <= 1'b0;
         FAIL_OUT <= 1'b0;
         res_cnt_q <= 10'h000;
      end else if (CLK_EN) begin
         if (ev[troc_pkg::E_PASS] || ev[troc_pkg::E_FAIL]) begin
            PASS_OUT <= ev[troc_pkg::E_PASS] && mode_of(ctrl_q[1:0]) != troc_pkg::M_OFF;
            FAIL_OUT <= ev[troc_pkg::E_FAIL] && !ev[troc_pkg::E_PASS] && mode_of(ctrl_q[3:2]) != troc_pkg::M_OFF;
            res_cnt_q <= ev[troc_pkg::E_PASS] ? pass_time_q : fail_time_q; // R1
         end else begin
            if (tick && res_cnt_q != 10'h000)
               res_cnt_q <= res_cnt_q - 10'h001; // R21
            if (mode_of(ctrl_q[1:0]) == troc_pkg::M_TIME && tick && res_cnt_q <= 10'h001)
               PASS_OUT <= 1'b0; // R1
            if (mode_of(ctrl_q[3:2]) == troc_pkg::M_TIME && tick && res_cnt_q <= 10'h001)
               FAIL_OUT <= 1'b0; // R1
            if (mode_of(ctrl_q[1:0]) == troc_pkg::M_SAFETY && !SAFETY_IN)
               PASS_OUT <= 1'b0; // R6
            if (mode_of(ctrl_q[3:2]) == troc_pkg::M_SAFETY && !SAFETY_IN)
               FAIL_OUT <= 1'b0; // R6
            // latch mode holds until the next start
            if (PLAN_START || ev[troc_pkg::E_STEP_START]) begin
               PASS_OUT <= 1'b0;
               FAIL_OUT <= 1'b0;
            end
         end
      end
   end

   // plan start from safety input rising edge, whole plan only
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         safety_prev_q <= 1'b0;
         PLAN_START <= 1'b0;
      end else if (CLK_EN) begin
         safety_prev_q <= SAFETY_IN;
         PLAN_START <= SAFETY_IN && !safety_prev_q &&
                       (mode_of(ctrl_q[1:0]) == troc_pkg::M_SAFETY || mode_of(ctrl_q[3:2]) == troc_pkg::M_SAFETY); // R7
      end
   end

   // buzzer; power-on beep stays silent as the pass beep enable resets clear
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         por_beep_q <= 1'b1;
         tone_cnt_q <= 10'h000;
         BUZZER <= 1'b0;
      end else if (CLK_EN) begin
         if (ev[troc_pkg::E_PASS] && ctrl_q[C_BEEP_PASS]) begin
            tone_cnt_q <= tone_pass_q; // R8
         end else if (ev[troc_pkg::E_FAIL] && ctrl_q[C_BEEP_FAIL]) begin
            tone_cnt_q <= tone_fail_q; // R8
         end else if (por_beep_q) begin
            por_beep_q <= 1'b0;
            if (ctrl_q[C_BEEP_PASS])
               tone_cnt_q <= tone_pass_q; // R9
         end else if (tick && tone_cnt_q != 10'h000) begin
            tone_cnt_q <= tone_cnt_q - 10'h001;
         end
         BUZZER <= tone_cnt_q != 10'h000;
      end
   end

   // status routing or per-step general controls
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         gpo0_q <= 1'b0;
         gpo1_q <= 1'b0;
         SAFETY_CLOSED_OUT <= 1'b0;
         CONTACT_CLOSED_OUT <= 1'b0;
      end else if (CLK_EN) begin
         if (ev[troc_pkg::E_STEP_START]) begin
            gpo0_q <= ev[troc_pkg::E_GPO0];
            gpo1_q <= ev[troc_pkg::E_GPO1];
         end
         SAFETY_CLOSED_OUT <= ctrl_q[C_ROUTE_SUP] ? gpo0_q : SAFETY_CLOSED; // R10 R11
         CONTACT_CLOSED_OUT <= ctrl_q[C_ROUTE_SUP] ? gpo1_q : CONTACT_CLOSED; // R10 R11
      end
   end

   // step handshake and warning lamp
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         test_active_q <= 1'b0;
         IN_OPERATION <= 1'b0;
         READY_OUT <= 1'b1;
         flash_q <= 4'h0;
         WARN_LAMP <= 1'b0;
      end else if (CLK_EN) begin
         if (ev[troc_pkg::E_STEP_START] || PLAN_START) begin
            test_active_q <= 1'b1;
            IN_OPERATION <= 1'b1; // R20
            READY_OUT <= 1'b0; // R20
         end else if (ev[troc_pkg::E_STEP_DONE]) begin
            test_active_q <= 1'b0;
            IN_OPERATION <= 1'b0; // R20
            READY_OUT <= 1'b1; // R20
         end
         if (tick)
            flash_q <= (flash_q == FLASH_HALF) ? troc_pkg::FLASH_TICKS : flash_q + 4'h1;
         if (!test_active_q)
            WARN_LAMP <= 1'b0;
         else if (!ctrl_q[C_LAMP_FLASH])
            WARN_LAMP <= 1'b1;
         else if (tick && flash_q == FLASH_HALF)
            WARN_LAMP <= !WARN_LAMP; // R15
      end
   end
   // relay matrix
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         MATRIX_ON <= 1'b0;
         MATRIX_DEFAULT <= 1'b1;
         mtx_armed_q <= 1'b0;
         idle_cnt_q <= 14'h0000;
      end else if (CLK_EN) begin
         if (ev[troc_pkg::E_MTX_ARM]) begin
            MATRIX_ON <= 1'b1;
            MATRIX_DEFAULT <= 1'b0;
            mtx_armed_q <= 1'b1;
            idle_cnt_q <= 14'h0000;
         end else if (ev[troc_pkg::E_STEP_START] || PLAN_START) begin
            mtx_armed_q <= 1'b0;
         end else if (mtx_armed_q && tick && !(ctrl_q[C_MTX_HOLD] && ctrl_q[C_CONTACT_START])) begin // R14
            if (idle_cnt_q == troc_pkg::IDLE_TICKS - 14'h0001) begin
               MATRIX_ON <= 1'b0; // R13
               mtx_armed_q <= 1'b0;
            end else begin
               idle_cnt_q <= idle_cnt_q + 14'h0001;
            end
         end
         if (ev[troc_pkg::E_PLAN_END] && !ctrl_q[C_HOLD_POS])
            MATRIX_DEFAULT <= 1'b1; // R12
      end
   end

   // adaptive hv start and analog enable
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         stable_q <= 3'h0;
         volt_q <= 16'h0000;
         load_q <= 16'h0000;
         LOAD_MEASURE <= 1'b1;
         ANALOG_EN <= 1'b1;
      end else if (CLK_EN) begin
         ANALOG_EN <= !ctrl_q[C_ANALOG_DIS]; // R19
         if (wr && PADDR == troc_pkg::A_LOAD) begin
            volt_q <= PWDATA[31:16];
            load_q <= PWDATA[15:0];
            if (PWDATA[31:16] != volt_q || PWDATA[15:0] != load_q)
               stable_q <= 3'h0; // R18
         end else if (ev[troc_pkg::E_UNIT] && stable_q != STABLE_UNITS) begin
            stable_q <= stable_q + 3'h1; // R17
         end
         LOAD_MEASURE <= AC_HV_TEST && !(ctrl_q[C_ADAPTIVE] && stable_q == STABLE_UNITS); // R16 R17
      end
   end
endmodule // troc_top

// ===== verif/tb.sv
// self-checking bench for the result output control block
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic want = 1'b0;
   logic sc = 1'b0;
   logic cc = 1'b0;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, rv;
   logic rdy, err, po, fo, sco, cco, inop, rdo, plan, buz, wl, mon, mdef, lm, aen, sin, hv;
   logic [15:0] lf = 16'hd9a2;
   int n_fail = 0;
   int num_checks = 0;
   int n_plan = 0;
   int ctrl;
   int i;
   int v;
   always #5 clk = ~clk;
   troc_top u_dut (.CORE_CLK(clk), .NRST(nrst), .CLK_EN(1'b1), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err), .SAFETY_IN(sin),
      .SAFETY_CLOSED(sc), .CONTACT_CLOSED(cc), .AC_HV_TEST(hv), .PASS_OUT(po), .FAIL_OUT(fo),
      .SAFETY_CLOSED_OUT(sco), .CONTACT_CLOSED_OUT(cco), .IN_OPERATION(inop), .READY_OUT(rdo),
      .PLAN_START(plan), .BUZZER(buz), .WARN_LAMP(wl), .MATRIX_ON(mon), .MATRIX_DEFAULT(mdef),
      .LOAD_MEASURE(lm), .ANALOG_EN(aen));
   // spans shortened so a start fits in the run
   troc_ctl_model #(.HOLD_CYC(20), .GAP_CYC(60)) u_ctl (.clk(clk), .want(want), .safety_in(sin), .hv_test(hv));
   always @(posedge clk) if (plan === 1'b1) n_plan++;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int clamp(input int d);
      return (d > 1000) ? 1000 : d;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_pin(input string nm, input logic e, input logic g);
      chk_reg(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      // no cycle limit here; the watchdog ends a hung transfer
      do begin
         @(posedge clk);
      end while (rdy !== 1'b1);
      rv = prd;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input int d);
      apb(1'b1, a, 32'(d));
      if (a == troc_pkg::A_CTRL) ctrl = d;
      cyc(3);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input int e);
      apb(1'b0, a, 32'h0);
      chk_reg(nm, 32'(e), rv);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      cyc(10);
      nrst <= 1'b1;
      cyc(2);
      chk_pin("ready", 1'b1, rdo);
      chk_pin("buzzer", 1'b0, buz);
      // no hv test running yet, so no load measurement is asked for
      chk_pin("load_measure", 1'b0, lm);
      rd("ctrl", troc_pkg::A_CTRL, troc_pkg::CTRL_RST);
      rd("tone_pass", troc_pkg::A_TONE_PASS, 200);
      rd("tone_fail", troc_pkg::A_TONE_FAIL, 500);
      apb(1'b0, 8'h20, 32'h0);
      chk_pin("slverr", 1'b1, err);
      $display("test reset done");
      wr(troc_pkg::A_PASS_TIME, 2000);
      rd("pass_time", troc_pkg::A_PASS_TIME, clamp(2000));
      for (i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         v = lf % 1000 + 1;
         wr(troc_pkg::A_FAIL_TIME, v);
         rd("fail_time", troc_pkg::A_FAIL_TIME, clamp(v));
      end
      wr(troc_pkg::A_CTRL, 0);
      for (i = 0; i < 6; i++) begin
         lf = lfsr(lf);
         sc <= lf[0];
         cc <= lf[1];
         cyc(3);
         chk_pin("sc_out", lf[0], sco);
         chk_pin("cc_out", lf[1], cco);
      end
      wr(troc_pkg::A_CTRL, 32'h40);
      for (i = 0; i < 4; i++) begin
         wr(troc_pkg::A_EVENT, 32'h8 | (i << troc_pkg::E_GPO0));
         chk_pin("gpo0", i[0], sco);
         chk_pin("gpo1", i[1], cco);
         chk_pin("in_op", 1'b1, inop);
         chk_pin("lamp", 1'b1, wl);
         wr(troc_pkg::A_EVENT, 32'h10);
         chk_pin("ready_back", 1'b1, rdo);
         chk_pin("lamp_off", 1'b0, wl);
      end
      $display("test routing done");
      // poll 40 ms plus 18 ms rounds up to six steps; the drop is past this run
      wr(troc_pkg::A_PASS_TIME, 6);
      wr(troc_pkg::A_CTRL, 32'h12);
      wr(troc_pkg::A_EVENT, 32'h1);
      chk_pin("pass", 1'b1, po);
      chk_pin("fail", 1'b0, fo);
      chk_pin("beep", 1'b1, buz);
      wr(troc_pkg::A_CTRL, 32'hc);
      want <= 1'b1;
      cyc(40);
      chk_reg("plan_starts", 32'h1, 32'(n_plan));
      wr(troc_pkg::A_EVENT, 32'h2);
      cyc(20);
      chk_pin("fail_held", 1'b1, fo);
      chk_pin("load_measure_hv", 1'b1, lm);
      want <= 1'b0;
      cyc(40);
      chk_pin("fail_drop", 1'b0, fo);
      $display("test results done");
      wr(troc_pkg::A_CTRL, 32'h800);
      chk_pin("analog", 1'b0, aen);
      wr(troc_pkg::A_CTRL, 32'h400);
      want <= 1'b1;
      wr(troc_pkg::A_LOAD, 32'h00e6_0100);
      for (i = 1; i <= 5; i++) begin
         wr(troc_pkg::A_EVENT, 32'h40);
         chk_pin("load_measure", i < 5, lm);
      end
      wr(troc_pkg::A_LOAD, 32'h00e6_0180);
      chk_pin("load_back", 1'b1, lm);
      wr(troc_pkg::A_CTRL, 0);
      wr(troc_pkg::A_EVENT, 32'h20);
      chk_pin("matrix_on", 1'b1, mon);
      chk_pin("matrix_moved", 1'b0, mdef);
      wr(troc_pkg::A_EVENT, 32'h4);
      chk_pin("matrix_default", 1'b1, mdef);
      rd("ctrl_model", troc_pkg::A_CTRL, ctrl);
      $display("test adaptive and matrix done");
      tally_and_finish;
   end
   initial begin
      cyc(20000);
      n_fail++;
      tally_and_finish;
   end
endmodule // tb

// ===== verif/troc_ctl_model.sv
// line controller model driving the safety circuit and hv start lines
`timescale 1ns/10ps
module troc_ctl_model #(
   parameter int HOLD_CYC = 1800000,
   parameter int GAP_CYC = 20000000
) (
   // clock
   input wire logic clk,
   // level the bench asks for
   input wire logic want,
   // lines toward the device
   output logic safety_in,
   output logic hv_test
);
   int held = 0;
   int since = 0;
   logic lvl = 1'b0;
   // a request is delayed until the hold span has run out, and a rise until the gap span has too; one withdrawn before then is dropped
   always @(posedge clk) begin
      held <= held + 1;
      since <= since + 1;
      if (want != lvl && held > HOLD_CYC && (!want || since > GAP_CYC)) begin
         lvl <= want;
         held <= 0;
         if (want) since <= 0;
      end
   end
   assign safety_in = lvl;
   assign hv_test = lvl;
endmodule // troc_ctl_model

// ===== verif/troc_top_sva.sv
// assertion checker for the result output control block
`timescale 1ns/10ps
module troc_chk (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic CLK_EN,
   // apb request
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   // control inputs
   input wire logic SAFETY_IN,
   input wire logic SAFETY_CLOSED,
   input wire logic CONTACT_CLOSED,
   // control outputs
   input wire logic PASS_OUT,
   input wire logic FAIL_OUT,
   input wire logic SAFETY_CLOSED_OUT,
   input wire logic CONTACT_CLOSED_OUT,
   input wire logic IN_OPERATION,
   input wire logic READY_OUT,
   input wire logic PLAN_START,
   input wire logic BUZZER,
   input wire logic ANALOG_EN
);
   logic [31:0] ctrl_q;
   logic wr_acc;
   logic evt;
   assign wr_acc = PSEL && PENABLE && PWRITE && CLK_EN;
   assign evt = wr_acc && PADDR == troc_pkg::A_EVENT;
   // shadow of the control word, taken from bus writes only
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         ctrl_q <= troc_pkg::CTRL_RST;
      end else if (wr_acc && PADDR == troc_pkg::A_CTRL) begin
         ctrl_q <= PWDATA;
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   sequence s_pass_evt;
      evt && PWDATA[troc_pkg::E_PASS] && ctrl_q[1:0] != 2'h0;
   endsequence
   sequence s_safe_rise;
      $rose(SAFETY_IN) && (ctrl_q[1:0] == 2'h3 || ctrl_q[3:2] == 2'h3);
   endsequence
   property p_rdy_inv;
      READY_OUT == !IN_OPERATION;
   endproperty
   a_rdy_inv: assert property (p_rdy_inv) else $error("ready is not the inverse of in-operation");
   property p_pass_evt;
      s_pass_evt |-> ##[1:2] PASS_OUT;
   endproperty
   a_pass_evt: assert property (p_pass_evt) else $error("pass output did not rise");
   property p_buzz;
      s_pass_evt ##0 ctrl_q[troc_pkg::C_BEEP_PASS] |-> ##[1:2] BUZZER;
   endproperty
   a_buzz: assert property (p_buzz) else $error("buzzer silent on pass");
   property p_fail_drop;
      CLK_EN && ctrl_q[3:2] == 2'h3 && !SAFETY_IN |-> ##[1:2] !FAIL_OUT;
   endproperty
   a_fail_drop: assert property (p_fail_drop) else $error("fail output outlived safety input");
   property p_plan_start;
      s_safe_rise |-> ##[1:2] PLAN_START;
   endproperty
   a_plan_start: assert property (p_plan_start) else $error("no plan start on safety rise");
   property p_plan_pulse;
      PLAN_START |=> !PLAN_START;
   endproperty
   a_plan_pulse: assert property (p_plan_pulse) else $error("plan start longer than one cycle");
   // ctrl held two cycles; outputs must follow the inputs after exactly one register stage
   property p_route;
      CLK_EN && !ctrl_q[6] && !$past(ctrl_q[6]) |=>
         SAFETY_CLOSED_OUT == $past(SAFETY_CLOSED) && CONTACT_CLOSED_OUT == $past(CONTACT_CLOSED);
   endproperty
   a_route: assert property (p_route) else $error("status not forwarded");
   property p_analog;
      ctrl_q[11] == $past(ctrl_q[11]) |-> ANALOG_EN == !ctrl_q[11];
   endproperty
   a_analog: assert property (p_analog) else $error("analog enable disagrees with control");
endmodule // troc_chk
bind troc_top troc_chk u_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .CLK_EN(CLK_EN), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .SAFETY_IN(SAFETY_IN),
   .SAFETY_CLOSED(SAFETY_CLOSED), .CONTACT_CLOSED(CONTACT_CLOSED), .PASS_OUT(PASS_OUT),
   .FAIL_OUT(FAIL_OUT), .SAFETY_CLOSED_OUT(SAFETY_CLOSED_OUT), .CONTACT_CLOSED_OUT(CONTACT_CLOSED_OUT),
   .IN_OPERATION(IN_OPERATION), .READY_OUT(READY_OUT), .PLAN_START(PLAN_START), .BUZZER(BUZZER),
   .ANALOG_EN(ANALOG_EN));
